// file: dps_host_model.sv
// Purpose: host model driving the shared select and clock
// Assumes: mode 0, 800 ns serial clock period
// Notes: low phase 500 ns so the chain's outputs settle
`timescale 1ns/1ps
module dps_host_model (
  output logic cs_n, // select to all devices
  output logic sck, // shared serial clock
  output logic sdi, // data into first device
  input wire logic sdo // data from last device
);
  initial begin
    cs_n = 1'h1;
    sck = 1'h0;
    sdi = 1'h0;
  end
  // one framed 32-bit exchange, msb first
  task automatic xfer(input logic [31:0] tx, output logic [31:0] rx);
    cs_n = 1'h0;
    for (int i = 31; i >= 0; i--) begin
      sdi = tx[i];
      #500;
      sck = 1'h1;
      rx = {rx[30:0], sdo};
      #300;
      sck = 1'h0;
    end
    #500;
    cs_n = 1'h1;
    sdi = ~sdi;
    #700;
  endtask : xfer
endmodule : dps_host_model

// file: dps_monitor.sv
// Purpose: port checks for the quad pot block
// Assumes: link pins slower than clk
// Notes: bound to every pot instance
`timescale 1ns/1ps
module dps_monitor #(
  parameter int unsigned NV_CYCLES = 50
) (
  input wire logic clk, // system clock
  input wire logic rstn, // reset, active low
  input wire logic cs_n, // chip select
  input wire logic sck, // serial clock
  input wire logic sdi, // serial data in
  input wire logic sdo_o, // data out level
  input wire logic sdo_oe, // data out enable
  input wire dps_pkg::dps_wipers_t wiper_pos, // wipers
  input wire logic shutdown_n, // shutdown, active low
  input wire logic write_in_progress // busy
);
  import dps_pkg::*;
  logic [31:0] busy_q, busy_d;
  // length of the busy span so far
  always_comb begin
    busy_d = write_in_progress ? busy_q + 32'h1 : 32'h0;
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      busy_q <= 32'h0;
    end else begin
      busy_q <= busy_d;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  chk_busy_len: assert property ($fell(write_in_progress) |-> busy_q == NV_CYCLES)
    else $error("busy length wrong");
  chk_busy_start: assert property ($rose(write_in_progress) |-> $past(cs_n, 3))
    else $error("busy began in frame");
  chk_wiper_at_end: assert property ($changed(wiper_pos) |-> $past(cs_n, 3))
    else $error("wiper moved in frame");
  chk_shdn_at_end: assert property ($changed(shutdown_n) |-> $past(cs_n, 3))
    else $error("shutdown moved in frame");
  chk_oe_idle: assert property (cs_n [*5] |-> !sdo_oe)
    else $error("output on while idle");
  chk_oe_select: assert property ($rose(sdo_oe) |-> !$past(cs_n, 2))
    else $error("output on unselected");
  chk_out_fall: assert property ($changed(sdo_o) |-> !$past(sck, 2))
    else $error("output moved off falling edge");
  chk_busy_hold: assert property (write_in_progress [*3] |-> $stable(wiper_pos) && $stable(shutdown_n))
    else $error("change while busy");
  cover property ($rose(write_in_progress));
  cover property ($changed(wiper_pos));
  cover property ($fell(shutdown_n));
endmodule : dps_monitor

// file: dps_nv_timer.sv
// Purpose: busy timer standing in for the non-volatile write cycle
// Assumes: start is a one-cycle pulse from the clk domain
// Notes: busy rises the cycle after start and holds for CYCLES cycles
`timescale 1ns/1ps
module dps_nv_timer #(
  parameter int unsigned CYCLES = dps_pkg::NV_WRITE_CYCLES
) (
  input wire logic clk, // system clock
  input wire logic rstn, // async reset, active low
  input wire logic start, // begin a write cycle
  output logic busy // write cycle running
);
  localparam int unsigned CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] CNT_LOAD = CW'(CYCLES);
  localparam logic [CW-1:0] CNT_ONE = CW'(1);

  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;

  // load on start, count down to idle
  always_comb begin
    cnt_d = cnt_q;
    if (start) begin
      cnt_d = CNT_LOAD;
    end else if (busy) begin
      cnt_d = cnt_q - CNT_ONE;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign busy = (cnt_q != '0);
endmodule : dps_nv_timer

// file: dps_pin_sync.sv
// Purpose: two-flop synchroniser with edge detection for one pin
// Assumes: pin is asynchronous to clk
// Notes: edges are taken between the second and third flops only
`timescale 1ns/1ps
module dps_pin_sync #(
  parameter logic RST_VAL = 1'b0
) (
  input wire logic clk, // system clock
  input wire logic rstn, // async reset, active low
  input wire logic pin, // raw pin level
  output logic level, // synchronised level
  output logic rise, // one-cycle pulse on rising edge
  output logic fall // one-cycle pulse on falling edge
);
  logic meta_q;
  logic sync_q;
  logic last_q;

  // sync chain plus one history flop
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
      last_q <= RST_VAL;
    end else begin
      meta_q <= pin;
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end

  // edge pulses from settled flops
  assign level = sync_q;
  assign rise = sync_q & ~last_q;
  assign fall = ~sync_q & last_q;
endmodule : dps_pin_sync

// file: dps_pkg.sv
// Purpose: shared constants and types for the quad pot serial access block
// Assumes: 10 MHz system clock; serial link sampled, not used as a clock
// Notes: instruction byte is opcode in upper three bits, address in lower five
package dps_pkg;

  // system clock and non-volatile write timing
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned NV_WRITE_MS = 20;
  localparam int unsigned NV_WRITE_CYCLES = (NV_WRITE_MS * CLK_HZ) / 1000;

  // frame geometry
  localparam int unsigned WORD_BITS = 16;
  localparam logic [3:0] BIT_CNT_LAST = 4'hF;
  localparam logic [3:0] BIT_CNT_ZERO = 4'h0;

  // opcodes
  localparam logic [2:0] OP_NOP = 3'h0;
  localparam logic [2:0] OP_ACR_RD = 3'h1;
  localparam logic [2:0] OP_ACR_WR = 3'h3;
  localparam logic [2:0] OP_REG_RD = 3'h4;
  localparam logic [2:0] OP_REG_WR = 3'h6;

  // register addresses
  localparam logic [4:0] ADDR_WIPER_LAST = 5'h03;
  localparam logic [4:0] ADDR_GP_FIRST = 5'h04;
  localparam logic [4:0] ADDR_GP_LAST = 5'h0E;
  localparam logic [4:0] ADDR_ACR = 5'h10;

  // access control field positions
  localparam int unsigned ACR_VOL_BIT = 7;
  localparam int unsigned ACR_SHDN_BIT = 6;
  localparam int unsigned ACR_WIP_BIT = 5;
  localparam int unsigned ACR_OD_BIT = 1;

  // reset values
  localparam logic ACR_VOL_RST = 1'b0;
  localparam logic ACR_SHDN_RST = 1'b1;
  localparam logic ACR_OD_RST = 1'b0;
  localparam logic [7:0] POWER_UP_RST = 8'h80;
  localparam logic [7:0] GP_RST = 8'h00;
  localparam logic [7:0] READ_ZERO = 8'h00;

  // storage sizes
  localparam int unsigned NUM_CHANNELS = 4;
  localparam int unsigned NV_WORDS = 15;

  typedef struct packed {
    logic [2:0] op;
    logic [4:0] addr;
  } dps_instr_t;

  typedef struct packed {
    dps_instr_t instr;
    logic [7:0] data;
  } dps_word_t;

  typedef logic [NUM_CHANNELS-1:0][7:0] dps_wipers_t;

endpackage : dps_pkg

// file: dps_spi_pot.sv
// Purpose: serial slave and register file of a quad digital potentiometer
// Assumes: link pins are asynchronous and sampled by the 10 MHz clock
// Notes: data output is a 16-bit delay of the input; instructions act at frame end
//   frames that are not a whole number of pairs execute nothing
//   the link pins pass two flops before use, so sck needs three clocks per phase
//   refused accesses leave every register as it was
//   wiper and power-up words share addresses; volatile select picks one for reads, and a write with it clear sets both
//   the access control byte is volatile and resets to shutdown off
`timescale 1ns/1ps
module dps_spi_pot #(
  parameter int unsigned NV_CYCLES = dps_pkg::NV_WRITE_CYCLES
) (
  input wire logic clk, // system clock
  input wire logic rstn, // async reset, active low
  input wire logic cs_n, // chip select pin, active low
  input wire logic sck, // serial clock pin
  input wire logic sdi, // serial data in pin
  output logic sdo_o, // serial data out level
  output logic sdo_oe, // serial data out enable
  output dps_pkg::dps_wipers_t wiper_pos, // wiper positions, channel 0 low
  output logic shutdown_n, // low puts all channels in shutdown
  output logic write_in_progress // non-volatile write running
);
  import dps_pkg::*;

  // synced pin levels and edge pulses
  logic cs_n_s;
  logic cs_rise;
  logic cs_fall;
  logic sck_rise;
  logic sck_fall;
  logic sdi_s;
  logic busy;
  logic nv_start;
  logic frame_on;

  // shift and framing state
  // count wraps every pair; full marks at least one whole pair
  dps_word_t sr_q;
  dps_word_t sr_d;
  logic [3:0] cnt_q;
  logic [3:0] cnt_d;
  logic full_q;
  logic full_d;
  logic sdo_q;
  logic sdo_d;

  // access control state
  // bit five is not stored: it is the timer's busy level
  logic vol_q;
  logic vol_d;
  logic shdn_q;
  logic shdn_d;
  logic od_q;
  logic od_d;

  // register storage
  // words 0 to 3 are power-up values, 4 to 14 general purpose
  // wipers are volatile and track the power-up words after reset
  dps_wipers_t wiper_q;
  dps_wipers_t wiper_d;
  logic [7:0] nv_q [0:NV_WORDS-1];
  logic [7:0] nv_d [0:NV_WORDS-1];

  // access control byte as read back
  // unused bits read as zero
  function automatic logic [7:0] acr_byte(input logic volatile_select, input logic shdn, input logic write_in_progress_flag, input logic od);
    logic [7:0] b;
    b = READ_ZERO;
    b[ACR_VOL_BIT] = volatile_select;
    b[ACR_SHDN_BIT] = shdn;
    b[ACR_WIP_BIT] = write_in_progress_flag;
    b[ACR_OD_BIT] = od;
    return b;
  endfunction : acr_byte

  // address falls in the general purpose range
  // the reserved word above the range falls outside
  function automatic logic is_gp(input logic [4:0] addr);
    return (addr >= ADDR_GP_FIRST) && (addr <= ADDR_GP_LAST);
  endfunction : is_gp

  // address selects the access control register
  function automatic logic is_acr(input logic [4:0] addr);
    return addr == ADDR_ACR;
  endfunction : is_acr

  // address selects a wiper or power-up value pair
  function automatic logic is_wiper(input logic [4:0] addr);
    return addr <= ADDR_WIPER_LAST;
  endfunction : is_wiper

  // pin synchronisers
  // select idles high so reset does not fake a frame start
  // clock and data idle low in mode 0
  // edges come out two clocks late, which sets the
  // shortest serial clock phase the block accepts
  // data is sampled from the second flop only
  // no logic reads the first flop of any chain
  dps_pin_sync #(.RST_VAL(1'b1)) u_cs_sync (
    .clk(clk),
    .rstn(rstn),
    .pin(cs_n),
    .level(cs_n_s),
    .rise(cs_rise),
    .fall(cs_fall)
  );

  dps_pin_sync #(.RST_VAL(1'b0)) u_sck_sync (
    .clk(clk),
    .rstn(rstn),
    .pin(sck),
    .level(),
    .rise(sck_rise),
    .fall(sck_fall)
  );

  dps_pin_sync #(.RST_VAL(1'b0)) u_sdi_sync (
    .clk(clk),
    .rstn(rstn),
    .pin(sdi),
    .level(sdi_s),
    .rise(),
    .fall()
  );

  // non-volatile write cycle timer
  // started only by a frame end that stores a byte
  // while it runs, only the access control byte may be read
  // the busy level doubles as the flag read back in bit five
  // a new start while busy reloads the count, though writes are refused then
  dps_nv_timer #(.CYCLES(NV_CYCLES)) u_nv_timer (
    .clk(clk),
    .rstn(rstn),
    .start(nv_start),
    .busy(busy)
  );

  // frame is open while the synced select is low
  assign frame_on = ~cs_n_s;

  // shifting, framing and instruction execution
  // a frame start clears the bit count and puts out the oldest held bit
  // each rising serial edge shifts one bit in, msb first
  // each falling serial edge moves the output to the next held bit
  // so the output trails the input by exactly one pair
  // a frame end with a whole number of pairs executes the pair
  // that arrived last; in a chain that is this device's own pair
  // a frame end with a partial pair leaves the held bits as they are
  // reads only load the answer into the data byte of the held pair,
  // which the next frame then shifts out behind the echoed instruction
  // refused reads leave the dummy byte in place
  // refused writes change nothing
  // only one event is acted on per clock; the select edges win
  // the select edge and a serial edge never fall in one clock
  //   when the host keeps its setup and hold around the select
  // an access control write takes bits seven, six and one
  // a power-up value write also moves the wiper
  always_comb begin
    sr_d = sr_q;
    cnt_d = cnt_q;
    full_d = full_q;
    sdo_d = sdo_q;
    vol_d = vol_q;
    shdn_d = shdn_q;
    od_d = od_q;
    wiper_d = wiper_q;
    nv_d = nv_q;
    nv_start = 1'b0;
    if (cs_fall) begin
      // new frame: first bit out is the oldest held bit
      cnt_d = BIT_CNT_ZERO;
      full_d = 1'b0;
      sdo_d = sr_q[WORD_BITS-1];
    end else if (frame_on && sck_rise) begin
      // sample on rising edge, msb first
      sr_d = {sr_q[WORD_BITS-2:0], sdi_s};
      cnt_d = cnt_q + 4'h1;
      if (cnt_q == BIT_CNT_LAST) begin
        full_d = 1'b1;
      end
    end else if (frame_on && sck_fall) begin
      // change output on falling edge, 16 bits behind input
      sdo_d = sr_q[WORD_BITS-1];
    end else if (cs_rise && full_q && (cnt_q == BIT_CNT_ZERO)) begin
      // last whole pair held is this device's instruction
      unique case (sr_q.instr.op)
        OP_ACR_RD: begin
          sr_d.data = acr_byte(vol_q, shdn_q, busy, od_q);
        end
        OP_ACR_WR: begin
          if (!busy) begin
            vol_d = sr_q.data[ACR_VOL_BIT];
            shdn_d = sr_q.data[ACR_SHDN_BIT];
            od_d = sr_q.data[ACR_OD_BIT];
          end
        end
        OP_REG_RD: begin
          // echoed instruction stays in the upper byte
          // reserved and unmapped addresses answer zero
          if (is_acr(sr_q.instr.addr)) begin
            sr_d.data = acr_byte(vol_q, shdn_q, busy, od_q);
          end else if (busy) begin
            sr_d.data = sr_q.data;
          end else if (is_wiper(sr_q.instr.addr)) begin
            if (vol_q) begin
              sr_d.data = wiper_q[sr_q.instr.addr[1:0]];
            end else begin
              sr_d.data = nv_q[sr_q.instr.addr[3:0]];
            end
          end else if (is_gp(sr_q.instr.addr) && !vol_q) begin
            sr_d.data = nv_q[sr_q.instr.addr[3:0]];
          end else begin
            sr_d.data = READ_ZERO;
          end
        end
        OP_REG_WR: begin
          if (!busy) begin
            if (is_acr(sr_q.instr.addr)) begin
              vol_d = sr_q.data[ACR_VOL_BIT];
              shdn_d = sr_q.data[ACR_SHDN_BIT];
              od_d = sr_q.data[ACR_OD_BIT];
            end else if (is_wiper(sr_q.instr.addr)) begin
              wiper_d[sr_q.instr.addr[1:0]] = sr_q.data;
              if (!vol_q) begin
                nv_d[sr_q.instr.addr[3:0]] = sr_q.data;
                nv_start = 1'b1;
              end
            end else if (is_gp(sr_q.instr.addr) && !vol_q) begin
              nv_d[sr_q.instr.addr[3:0]] = sr_q.data;
              nv_start = 1'b1;
            end
          end
        end
        default: begin
          // no-op and undefined opcodes do nothing
        end
      endcase
    end
  end

  // state registers
  // every register resets to its power-up value
  // general purpose words reset to zero, power-up words to mid scale
  // the data output rests low until a frame starts
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sr_q <= '0;
      cnt_q <= BIT_CNT_ZERO;
      full_q <= 1'b0;
      sdo_q <= 1'b0;
      vol_q <= ACR_VOL_RST;
      shdn_q <= ACR_SHDN_RST;
      od_q <= ACR_OD_RST;
      wiper_q <= {NUM_CHANNELS{POWER_UP_RST}};
      for (int i = 0; i < NV_WORDS; i++) begin
        nv_q[i] <= (i < NUM_CHANNELS) ? POWER_UP_RST : GP_RST;
      end
    end else begin
      sr_q <= sr_d;
      cnt_q <= cnt_d;
      full_q <= full_d;
      sdo_q <= sdo_d;
      vol_q <= vol_d;
      shdn_q <= shdn_d;
      od_q <= od_d;
      wiper_q <= wiper_d;
      nv_q <= nv_d;
    end
  end

  // output pin: push-pull or open drain while selected
  // open drain drives only the low level and lets the pull-up give the high
  // push-pull drives both levels while the frame is open
  // the pin is released whenever the select is seen high
  assign sdo_o = sdo_q & ~od_q;
  assign sdo_oe = frame_on & (~od_q | ~sdo_q);

  // block outputs
  // wipers follow their registers; shutdown and busy are levels
  assign wiper_pos = wiper_q;
  assign shutdown_n = shdn_q;
  assign write_in_progress = busy;
endmodule : dps_spi_pot

// file: tb_dps_spi_pot.sv
// Purpose: two chained pots driven by a host model
// Assumes: 10 MHz clk, 800 ns serial clock
// Notes: each frame has one pair per device, far one first
`timescale 1ns/1ps
module tb_dps_spi_pot;
  import dps_pkg::*;
  localparam int unsigned NV_CYCLES = 2000;
  logic clk, rstn, cs_n, sck, sdi, mid, sdo;
  logic sdo0_o, sdo0_oe, sdo1_o, sdo1_oe, shdn0, shdn1, wip0, wip1;
  dps_wipers_t wiper0, wiper1;
  logic [31:0] rx;
  int num_errors = 0;
  int cmp_count = 0;
  // released data lines float high
  assign mid = sdo0_oe ? sdo0_o : 1'h1;
  assign sdo = sdo1_oe ? sdo1_o : 1'h1;
  dps_host_model u_dps_host_model (.cs_n(cs_n), .sck(sck), .sdi(sdi), .sdo(sdo));
  dps_spi_pot #(.NV_CYCLES(NV_CYCLES)) u_dps_spi_pot (.clk(clk), .rstn(rstn), .cs_n(cs_n), .sck(sck), .sdi(sdi),
    .sdo_o(sdo0_o), .sdo_oe(sdo0_oe), .wiper_pos(wiper0), .shutdown_n(shdn0), .write_in_progress(wip0));
  dps_spi_pot #(.NV_CYCLES(NV_CYCLES)) u_dps_spi_pot_1 (.clk(clk), .rstn(rstn), .cs_n(cs_n), .sck(sck), .sdi(mid),
    .sdo_o(sdo1_o), .sdo_oe(sdo1_oe), .wiper_pos(wiper1), .shutdown_n(shdn1), .write_in_progress(wip1));
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // two-frame read, answers far device first
  task automatic rd(input logic [15:0] ins, input logic [31:0] exp);
    u_dps_host_model.xfer({ins[15:8], 8'h00, ins[7:0], 8'h00}, rx);
    u_dps_host_model.xfer(32'h0000_0000, rx);
    check("read", rx, exp);
  endtask : rd
  task automatic wr(input logic [31:0] w);
    u_dps_host_model.xfer(w, rx);
  endtask : wr
  task automatic end_of_test();
    $display("compares %0d errors %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : end_of_test
  initial begin
    clk = 1'h0;
    forever #50 clk = ~clk;
  end
  initial begin
    #5_000_000;
    num_errors++;
    end_of_test();
  end
  initial begin
    rstn = 1'h0;
    repeat (16) @(posedge clk);
    rstn <= 1'h1;
    repeat (4) @(posedge clk);
    #37;
    check("wiper0", wiper0, 32'h8080_8080);
    check("idle", {shdn1, shdn0, wip1, wip0, sdo0_oe}, 32'h18);
    rd(16'h9020, 32'h9040_2040);
    wr(32'hC23C_C0A5);
    check("wiper1", wiper1, 32'h803C_8080);
    check("wiper0", wiper0, 32'h8080_80A5);
    check("busy", {wip1, wip0}, 32'h3);
    wr(32'h60C0_60C0);
    rd(16'h2020, 32'h2060_2060);
    repeat (NV_CYCLES + 20) @(posedge clk);
    #37;
    check("busy", {wip1, wip0}, 32'h0);
    rd(16'h2020, 32'h2040_2040);
    rd(16'h8280, 32'h823C_80A5);
    wr(32'h6080_60C0);
    check("shdn", {shdn1, shdn0}, 32'h1);
    wr(32'hC377_C111);
    check("wiper1", wiper1, 32'h773C_8080);
    check("wiper0", wiper0, 32'h8080_11A5);
    check("busy", {wip1, wip0}, 32'h0);
    rd(16'h8384, 32'h8377_8400);
    wr(32'hD040_D040);
    rd(16'h8381, 32'h8380_8180);
    check("wiper0", wiper0, 32'h8080_11A5);
    wr(32'hC442_CE99);
    repeat (NV_CYCLES + 20) @(posedge clk);
    #37;
    rd(16'h848E, 32'h8442_8E99);
    rd(16'h8F91, 32'h8F00_9100);
    end_of_test();
  end
endmodule : tb_dps_spi_pot
bind dps_spi_pot dps_monitor #(.NV_CYCLES(NV_CYCLES)) u_dps_monitor (.clk(clk), .rstn(rstn), .cs_n(cs_n),
  .sck(sck), .sdi(sdi), .sdo_o(sdo_o), .sdo_oe(sdo_oe), .wiper_pos(wiper_pos), .shutdown_n(shutdown_n),
  .write_in_progress(write_in_progress));
